// [edo_ctrl_pkg.sv]
package edo_ctrl_pkg;

  localparam int CLK_PERIOD_NS = 50;

  // Timing figures in ns (refresh window in ms), slower grade
  localparam int T_RAS_ACCESS_NS  = 60;
  localparam int T_PAGE_CYCLE_NS  = 40;
  localparam int T_RANDOM_CYC_NS  = 110;
  localparam int T_PRECHARGE_NS   = 50;
  localparam int T_REFRESH_WIN_MS = 16;
  localparam int REFRESH_ROWS     = 1024;

  function automatic int ceil_cycles(input int ns);
    ceil_cycles = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (ceil_cycles < 1) begin
      ceil_cycles = 1;
    end
  endfunction

  localparam int RAS_ACCESS_CYC = ceil_cycles(T_RAS_ACCESS_NS);
  localparam int PAGE_CYC       = ceil_cycles(T_PAGE_CYCLE_NS);
  localparam int RANDOM_CYC     = ceil_cycles(T_RANDOM_CYC_NS);
  localparam int PRECHARGE_CYC  = ceil_cycles(T_PRECHARGE_NS);
  // Longest interval rounds down
  localparam int REFRESH_INT_CYC =
    (T_REFRESH_WIN_MS * 1000000 / REFRESH_ROWS) / CLK_PERIOD_NS;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;

  typedef struct packed {
    logic        write;
    logic [1:0]  laneSel;
    logic [19:0] addr;
    logic [15:0] wdata;
  } req_s;

  typedef struct packed {
    logic        rasN;
    logic        casLoN;
    logic        casHiN;
    logic        weN;
    logic        oeN;
    logic [9:0]  addr;
  } pins_s;

endpackage

// [edo_dram_byte_lane_access.sv]
// Summary of operation
// - Row then column on shared address pins
// - Byte write asserts only that strobe
// - Byte read asserts only that strobe
// - Early word write, write-select low first
// - Upper byte write uses high strobe
// - Refresh: column strobe low before row
// - 1024 refreshes every 16 ms
// - Page cycle spacing at least 40 ns
// - Random cycle spacing at least 110 ns
// - Wait 60 ns after row strobe
// - Read starts at later strobe fall
`timescale 1ns/1ns
`default_nettype none
module edo_dram_byte_lane_access (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                reqValid,
  output logic                     reqReady,
  input  wire edo_ctrl_pkg::req_s  req,
  output logic                     rspValid,
  input  wire logic                rspReady,
  output logic [15:0]              rspData,
  output edo_ctrl_pkg::pins_s      pins,
  input  wire logic [15:0]         dataIn,
  output logic [15:0]              dataOut,
  output logic [15:0]              dataOeN
);
  import edo_ctrl_pkg::*;

  typedef enum logic [2:0] {
    IDLE = 3'b000, ROW = 3'b001, COL = 3'b011, WAITD = 3'b010,
    PRE = 3'b110, RFCAS = 3'b111, RFRAS = 3'b101
  } state_e;

  localparam int CNT_W = 14;

  state_e       state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] rfCnt_ff;
  logic         rfPend_ff;
  req_s         cur_ff;
  logic [15:0]  syn1_ff;
  logic [15:0]  syn2_ff;
  logic [15:0]  bufData_ff [2];
  logic [1:0]   bufCnt_ff;
  logic         bufWr_ff;
  logic         bufRd_ff;
  logic         capture;
  logic         bufFull;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  // Pin inputs pass two flops first
  always_ff @(posedge clk) begin
    syn1_ff <= dataIn;
    syn2_ff <= syn1_ff;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rfCnt_ff  <= '0;
      rfPend_ff <= 1'b0;
    end else if (rfCnt_ff == cyc(REFRESH_INT_CYC - 1)) begin
      rfCnt_ff  <= '0;
      rfPend_ff <= 1'b1;
    end else begin
      rfCnt_ff <= rfCnt_ff + 1'b1;
      if (state_ff == RFRAS) begin
        rfPend_ff <= 1'b0;
      end
    end
  end

  // Refresh outranks new requests; full buffer stalls all requests, writes included
  assign bufFull  = (bufCnt_ff == 2'd2);
  assign reqReady = (state_ff == IDLE) && !rfPend_ff && !bufFull;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= IDLE;
      cnt_ff   <= '0;
      cur_ff   <= '0;
    end else begin
      unique case (state_ff)
        IDLE: begin
          cnt_ff <= '0;
          if (rfPend_ff) begin
            state_ff <= RFCAS;
          end else if (reqValid && reqReady) begin
            cur_ff   <= req;
            state_ff <= ROW;
          end
        end
        // one column per row, page spacing moot
        ROW: begin
          state_ff <= COL;
          cnt_ff   <= cnt_ff + 1'b1;
        end
        COL: begin
          cnt_ff <= cnt_ff + 1'b1;
          // read data after row access time, plus sync
          if (cnt_ff >= cyc(RAS_ACCESS_CYC + 2)) begin
            state_ff <= WAITD;
          end
        end
        WAITD: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff >= cyc(RANDOM_CYC)) begin
            state_ff <= PRE;
            cnt_ff   <= '0;
          end
        end
        PRE: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff >= cyc(PRECHARGE_CYC - 1)) begin
            state_ff <= IDLE;
          end
        end
        // column strobes fall before row strobe
        RFCAS: begin
          state_ff <= RFRAS;
          cnt_ff   <= '0;
        end
        RFRAS: begin
          cnt_ff <= cnt_ff + 1'b1;
          if (cnt_ff >= cyc(RAS_ACCESS_CYC)) begin
            state_ff <= PRE;
            cnt_ff   <= '0;
          end
        end
        default: state_ff <= IDLE;
      endcase
    end
  end

  assign capture = (state_ff == COL) && !cur_ff.write &&
                   (cnt_ff >= cyc(RAS_ACCESS_CYC + 2));

  // Pin drive, registered
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pins    <= '{rasN: 1'b1, casLoN: 1'b1, casHiN: 1'b1, weN: 1'b1, oeN: 1'b1,
                   addr: '0};
      dataOut <= '0;
      dataOeN <= '1;
    end else begin
      pins    <= '{rasN: 1'b1, casLoN: 1'b1, casHiN: 1'b1, weN: 1'b1, oeN: 1'b1,
                   addr: pins.addr};
      dataOeN <= '1;
      unique case (state_ff)
        IDLE, PRE: ;
        ROW: begin
          pins.rasN <= 1'b0;
          pins.addr <= cur_ff.addr[19:10];
          pins.weN  <= !cur_ff.write;
        end
        COL, WAITD: begin
          pins.rasN <= 1'b0;
          // column half while row strobe low
          pins.addr <= cur_ff.addr[9:0];
          pins.weN  <= !cur_ff.write;
          pins.casLoN <= !cur_ff.laneSel[0];
          // upper byte alone on high strobe
          pins.casHiN <= !cur_ff.laneSel[1];
          pins.oeN <= cur_ff.write;
          // early write drives data with strobes
          if (cur_ff.write) begin
            dataOut <= cur_ff.wdata;
            dataOeN <= {{8{!cur_ff.laneSel[1]}}, {8{!cur_ff.laneSel[0]}}};
          end
        end
        RFCAS: begin
          pins.casLoN <= 1'b0;
          pins.casHiN <= 1'b0;
        end
        // column strobes stay low over refresh
        RFRAS: begin
          pins.rasN   <= 1'b0;
          pins.casLoN <= 1'b0;
          pins.casHiN <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  // Two-entry read buffer; host stall loses no word
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bufCnt_ff <= '0;
      bufWr_ff  <= 1'b0;
      bufRd_ff  <= 1'b0;
    end else begin
      bufCnt_ff <= bufCnt_ff + 2'(capture && !bufFull) - 2'(rspValid && rspReady);
      if (capture && !bufFull) begin
        bufWr_ff <= !bufWr_ff;
      end
      if (rspValid && rspReady) begin
        bufRd_ff <= !bufRd_ff;
      end
    end
  end

  // unselected read lane returned as zero
  always_ff @(posedge clk) begin
    if (capture && !bufFull) begin
      bufData_ff[bufWr_ff] <= syn2_ff &
        {{8{cur_ff.laneSel[1]}}, {8{cur_ff.laneSel[0]}}};
    end
  end

  assign rspValid = (bufCnt_ff != 2'd0);
  assign rspData  = bufData_ff[bufRd_ff];

endmodule
`default_nettype wire

// [edo_dram_model.sv]
`timescale 1ns/1ns
`default_nettype none
module edo_dram_model (
  input  wire logic                clk,
  input  wire edo_ctrl_pkg::pins_s pins,
  input  wire logic [15:0]         dataOut,
  output logic [15:0]              dataIn
);
  import edo_ctrl_pkg::*;
  logic [15:0] mem [int];
  logic [9:0]  rowFf;
  logic        cbrFf;
  logic        rasPrevFf;
  logic [15:0] lastFf;
  int          key;
  always_ff @(posedge clk) begin
    rasPrevFf <= pins.rasN;
    lastFf <= dataIn;
    if (rasPrevFf && !pins.rasN) begin
      rowFf <= pins.addr;
      cbrFf <= !pins.casLoN || !pins.casHiN;
    end
  end
  always_ff @(posedge clk) begin
    if (!pins.rasN && !cbrFf && !pins.weN) begin
      if (!pins.casLoN) mem[{rowFf, pins.addr}][7:0] <= dataOut[7:0];
      if (!pins.casHiN) mem[{rowFf, pins.addr}][15:8] <= dataOut[15:8];
    end
  end
  always_comb begin
    key = {rowFf, pins.addr};
    dataIn = ~lastFf;
    if (!pins.rasN && !cbrFf && !pins.oeN && pins.weN) begin
      if (!pins.casLoN) dataIn[7:0] = mem[key][7:0];
      if (!pins.casHiN) dataIn[15:8] = mem[key][15:8];
    end
  end
endmodule
`default_nettype wire

// [edo_dram_byte_lane_access_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module edo_dram_byte_lane_access_asserts (
  input wire logic                clk,
  input wire logic                nrst,
  input wire logic                reqValid,
  input wire logic                reqReady,
  input wire edo_ctrl_pkg::req_s  req,
  input wire logic                rspValid,
  input wire logic                rspReady,
  input wire logic [15:0]         rspData,
  input wire edo_ctrl_pkg::pins_s pins,
  input wire logic [15:0]         dataIn,
  input wire logic [15:0]         dataOut,
  input wire logic [15:0]         dataOeN
);
  import edo_ctrl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Interval counter, slack for a busy access
  int refCnt;
  always_ff @(posedge clk) begin
    if (!nrst || ($fell(pins.rasN) && !pins.casLoN)) refCnt <= 0;
    else refCnt <= refCnt + 1;
  end
  sequence s_rowOpen;
    $fell(pins.rasN);
  endsequence
  property p_rowFirst;
    $fell(pins.casLoN) && !pins.rasN |-> $past(!pins.rasN);
  endproperty
  a_rowFirst: assert property (p_rowFirst) else $error("column before row");
  property p_rasHold;
    s_rowOpen |-> !pins.rasN [*3];
  endproperty
  a_rasHold: assert property (p_rasHold) else $error("row strobe too short");
  property p_spacing;
    s_rowOpen |-> ##1 (!$fell(pins.rasN)) [*3];
  endproperty
  a_spacing: assert property (p_spacing) else $error("cycles too close");
  property p_cbrOrder;
    $fell(pins.rasN) && !pins.casLoN |-> $past(!pins.casLoN);
  endproperty
  a_cbrOrder: assert property (p_cbrOrder) else $error("refresh order");
  property p_byteWrite;
    !pins.rasN && !pins.weN && !pins.casLoN && pins.casHiN |-> &dataOeN[15:8];
  endproperty
  a_byteWrite: assert property (p_byteWrite) else $error("upper lane driven");
  property p_readFloat;
    !pins.oeN |-> &dataOeN && pins.weN;
  endproperty
  a_readFloat: assert property (p_readFloat) else $error("drive during read");
  property p_refInt;
    refCnt <= REFRESH_INT_CYC + 16;
  endproperty
  a_refInt: assert property (p_refInt) else $error("refresh late");
  property p_rspHold;
    rspValid && !rspReady |=> rspValid && $stable(rspData);
  endproperty
  a_rspHold: assert property (p_rspHold) else $error("read word dropped");
endmodule
bind edo_dram_byte_lane_access edo_dram_byte_lane_access_asserts edo_dram_byte_lane_access_asserts_inst (
  .clk(clk), .nrst(nrst), .reqValid(reqValid), .reqReady(reqReady), .req(req),
  .rspValid(rspValid), .rspReady(rspReady), .rspData(rspData), .pins(pins),
  .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN));
`default_nettype wire

// [edo_dram_byte_lane_access_test.sv]
`timescale 1ns/1ns
`default_nettype none
module edo_dram_byte_lane_access_test;
  import edo_ctrl_pkg::*;
  logic clk, nrst, reqValid, reqReady, rspValid, rspReady, stall;
  req_s req;
  pins_s pins;
  logic [15:0] rspData, dataIn, dataOut, dataOeN, e, sh [int], eq [$];
  logic [19:0] ad [24];
  int miscompares, compares, cycles;
  edo_dram_byte_lane_access edo_dram_byte_lane_access_inst (.clk(clk), .nrst(nrst),
    .reqValid(reqValid), .reqReady(reqReady), .req(req), .rspValid(rspValid),
    .rspReady(rspReady), .rspData(rspData), .pins(pins), .dataIn(dataIn),
    .dataOut(dataOut), .dataOeN(dataOeN));
  edo_dram_model edo_dram_model_inst (.clk(clk), .pins(pins), .dataOut(dataOut),
    .dataIn(dataIn));
  task automatic give_verdict;
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [1:0] ls, input logic [19:0] a);
    logic [15:0] m, d;
    m = {{8{ls[1]}}, {8{ls[0]}}};
    d = 16'($urandom);
    if (w) sh[a] = sh[a] & ~m | d & m;
    else eq.push_back(sh[a] & m);
    @(posedge clk);
    #2;
    req = '{w, ls, a, d};
    reqValid = 1;
    while (reqReady !== 1'b1) begin
      @(posedge clk);
      #2;
    end
    @(posedge clk);
    #2;
    reqValid = 0;
  endtask
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // Random stalls by the reader
  always @(posedge clk) begin
    #2 rspReady = !stall && ($urandom % 4 != 0);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      give_verdict;
    end
    if (nrst && rspValid === 1'b1 && rspReady === 1'b1) begin
      e = eq.pop_front();
      compares++;
      if (rspData !== e) begin
        miscompares++;
        $display("CHECK FAILED rspData exp %h got %h", e, rspData);
      end
    end
  end
  initial begin
    void'($urandom(4388));
    {nrst, reqValid, rspReady, stall, req} = '0;
    repeat (20) @(posedge clk);
    #2 nrst = 1;
    foreach (ad[i]) ad[i] = 20'($urandom);
    foreach (ad[i]) acc(1, 2'h3, ad[i]);
    foreach (ad[i]) acc(1, 2'(1 + i % 2), ad[i]);
    foreach (ad[i]) acc(0, 2'(1 + i % 3), ad[i]);
    // Drain first, or a leftover word fills the buffer early
    while (eq.size() != 0) @(posedge clk);
    #2 stall = 1;
    acc(0, 2'h3, ad[0]);
    acc(0, 2'h1, ad[1]);
    repeat (12) @(posedge clk);
    compares++;
    // Buffer full must refuse
    if (reqReady !== 1'b0) begin
      miscompares++;
      $display("CHECK FAILED reqReady exp 0 got %b", reqReady);
    end
    stall = 0;
    repeat (700) @(posedge clk);
    for (int i = 0; i < 4; i++) acc(0, 2'h3, ad[i]);
    while (eq.size() != 0) @(posedge clk);
    give_verdict;
  end
endmodule
`default_nettype wire
